// [design/adcacc_ctrl.sv]
`default_nettype none
module adcacc_ctrl
  import adcacc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        lpo_clk_en_i,
  input  wire logic        burst_mode_enable_i,
  input  wire logic        conv_start_i,
  input  wire logic        done_clear_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  output logic             conversion_clock_o,
  output logic             core_start_o,
  output logic             core_track_o,
  output logic             eight_bit_select_o,
  output logic             twelve_bit_select_o,
  output logic             input_gain_select_o,
  input  wire logic        core_done_i,
  input  wire logic [11:0] core_code_i,
  output logic             conversion_done_flag_o,
  output logic             busy_o
);
  logic [7:0]    conv_cfg_q;
  logic [7:0]    acc_cfg_q;
  logic [15:0]   accum_q;
  logic [4:0]    div_cnt_q;
  logic          sar_clk_q;
  logic          sar_tick;
  logic          src_tick;
  adcacc_state_t state_q;
  logic [1:0]    trk_cnt_q;
  logic [6:0]    conv_left_q;
  logic          done_q;
  logic [15:0]   fmt_data;

  function automatic logic [6:0] rpt_count(input logic [2:0] f);
    case (f)
      3'h1:    rpt_count = 7'h04;
      3'h2:    rpt_count = 7'h08;
      3'h3:    rpt_count = 7'h10;
      3'h4:    rpt_count = 7'h20;
      3'h5:    rpt_count = 7'h40;
      default: rpt_count = 7'h01;
    endcase
  endfunction

  // ==========================================================
  // Registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_cfg_q <= RST_CONV_CFG;
      acc_cfg_q  <= RST_ACC_CFG;
    end else if (sfr_wr_i) begin
      if (sfr_addr_i == ADDR_CONV_CFG) begin
        conv_cfg_q <= sfr_wdata_i;
      end else if (sfr_addr_i == ADDR_ACC_CFG) begin
        acc_cfg_q <= sfr_wdata_i;
      end
    end
  end

  // ==========================================================
  // Conversion clock
  // Source select
  assign src_tick = burst_mode_enable_i ? lpo_clk_en_i : 1'b1;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt_q <= 5'h00;
      sar_clk_q <= 1'b0;
    end else if (src_tick) begin
      if (div_cnt_q >= conv_cfg_q[DIV_MSB:DIV_LSB]) begin
        div_cnt_q <= 5'h00;
        sar_clk_q <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 5'h01;
        sar_clk_q <= 1'b0;
      end
    end else begin
      sar_clk_q <= 1'b0;
    end
  end
  assign sar_tick           = sar_clk_q;
  assign conversion_clock_o = sar_clk_q;

  assign eight_bit_select_o  = conv_cfg_q[EIGHT_BIT];
  assign twelve_bit_select_o = acc_cfg_q[TWELVE_BIT];
  assign input_gain_select_o = conv_cfg_q[GAIN_BIT];

  // ==========================================================
  // Sequencer
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q     <= ADCACC_IDLE;
      trk_cnt_q   <= 2'h0;
      conv_left_q <= 7'h00;
    end else begin
      case (state_q)
        ADCACC_IDLE: begin
          if (conv_start_i) begin
            conv_left_q <= burst_mode_enable_i ? rpt_count(acc_cfg_q[RPT_MSB:RPT_LSB]) : 7'h01;
            trk_cnt_q   <= 2'h0;
            state_q     <= conv_cfg_q[TRACK_BIT] ? ADCACC_TRACK : ADCACC_CONV;
          end
        end
        ADCACC_TRACK: begin
          if (sar_tick) begin
            if (trk_cnt_q == TRACK_DELAY_CLKS - 2'h1) begin
              state_q <= ADCACC_CONV;
            end else begin
              trk_cnt_q <= trk_cnt_q + 2'h1;
            end
          end
        end
        ADCACC_CONV: begin
          if (core_done_i) begin
            conv_left_q <= conv_left_q - 7'h01;
            trk_cnt_q   <= 2'h0;
            if (conv_left_q == 7'h01) begin
              state_q <= ADCACC_IDLE;
            end else if (conv_cfg_q[TRACK_BIT]) begin
              state_q <= ADCACC_TRACK;
            end
          end
        end
        default: state_q <= ADCACC_IDLE;
      endcase
    end
  end
  // Start is held while converting; the core aborts nothing mid-burst
  assign core_start_o = (state_q == ADCACC_CONV);
  assign core_track_o = (state_q != ADCACC_CONV);
  assign busy_o       = (state_q != ADCACC_IDLE);

  // ==========================================================
  // Accumulator
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      accum_q <= 16'h0000;
    end else if (state_q == ADCACC_CONV && core_done_i) begin
      if (burst_mode_enable_i || acc_cfg_q[ACCUM_BIT]) begin
        accum_q <= accum_q + {4'h0, core_code_i};
      end else begin
        accum_q <= {4'h0, core_code_i};
      end
    end else if (sfr_wr_i && sfr_addr_i == ADDR_RES_HIGH) begin
      accum_q[15:8] <= sfr_wdata_i;
    end else if (sfr_wr_i && sfr_addr_i == ADDR_RES_LOW) begin
      accum_q[7:0] <= sfr_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_q <= 1'b0;
    end else if (state_q == ADCACC_CONV && core_done_i && conv_left_q == 7'h01) begin
      done_q <= 1'b1;
    end else if (done_clear_i) begin
      done_q <= 1'b0;
    end
  end
  assign conversion_done_flag_o = done_q;

  // ==========================================================
  // Read path
  // Read-only formatting
  always_comb begin
    case (acc_cfg_q[SJ_MSB:SJ_LSB])
      3'h1:    fmt_data = {1'b0, accum_q[15:1]};
      3'h2:    fmt_data = {2'h0, accum_q[15:2]};
      3'h3:    fmt_data = {3'h0, accum_q[15:3]};
      SJ_LEFT: fmt_data = {accum_q[11:0], 4'h0};
      default: fmt_data = accum_q;
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      if (sfr_addr_i == ADDR_CONV_CFG) begin
        sfr_rdata_o <= conv_cfg_q;
      end else if (sfr_addr_i == ADDR_ACC_CFG) begin
        sfr_rdata_o <= {acc_cfg_q[7], 1'b0, acc_cfg_q[5:0]};
      end else if (sfr_addr_i == ADDR_RES_HIGH) begin
        sfr_rdata_o <= fmt_data[15:8];
      end else if (sfr_addr_i == ADDR_RES_LOW) begin
        sfr_rdata_o <= fmt_data[7:0];
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end
endmodule // adcacc_ctrl
`default_nettype wire

// [dv/adcacc_core_model.sv]
`default_nettype none
// ======
// Converter core model
module adcacc_core_model #(
  parameter int          LAT  = 4,
  parameter logic [11:0] CODE = 12'h123
) (
  input  wire logic        mclk_i, sys_rst_i, start_i, tick_i,
  output logic             done_o,
  output logic      [11:0] code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // Code only valid beside done, so a late capture sees garbage
  assign code_o = done_o ? CODE : ~CODE;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q  <= 4'h0;
      done_o <= 1'b0;
    end else begin
      cnt_q  <= (!start_i || done_o) ? 4'h0 : cnt_q + 4'(tick_i);
      done_o <= start_i && !done_o && tick_i && cnt_q == 4'(LAT - 1);
    end
  end
endmodule // adcacc_core_model
`default_nettype wire

// [dv/adcacc_ctrl_assertions.sv]
`default_nettype none
// ======
// Checker
module adcacc_chk
  import adcacc_pkg::*;
(
  input wire logic       mclk_i, sys_rst_i, conv_start_i, done_clear_i, sfr_wr_i, sfr_rd_i,
  input wire logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o,
  input wire logic       eight_bit_select_o, twelve_bit_select_o, input_gain_select_o,
  input wire logic       core_done_i, conversion_done_flag_o, busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic fl = conversion_done_flag_o;
  wire logic cw = sfr_wr_i && sfr_addr_i == ADDR_CONV_CFG;
  wire logic aw = sfr_wr_i && sfr_addr_i == ADDR_ACC_CFG;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_start_taken: assert property (conv_start_i && !busy_o |=> busy_o)
    else $error("start ignored");
  a_flag_cause: assert property ($rose(fl) |-> $past(core_done_i))
    else $error("flag without done");
  a_flag_hold: assert property (fl && !done_clear_i |=> fl)
    else $error("flag lost");
  a_flag_clear: assert property (done_clear_i && !core_done_i |=> !fl)
    else $error("flag not cleared");
  a_eight_sel: assert property (cw |=> eight_bit_select_o == $past(sfr_wdata_i[2]))
    else $error("eight bit select wrong");
  a_gain_sel: assert property (cw |=> input_gain_select_o == $past(sfr_wdata_i[0]))
    else $error("gain select wrong");
  a_twelve_sel: assert property (aw |=> twelve_bit_select_o == $past(sfr_wdata_i[7]))
    else $error("twelve bit select wrong");
  a_accum_rd_zero: assert property (sfr_rd_i && sfr_addr_i == ADDR_ACC_CFG
    |=> !sfr_rdata_o[6])
    else $error("accumulate bit read back");
endmodule // adcacc_chk
bind adcacc_ctrl adcacc_chk i_adcacc_chk (.*);
`default_nettype wire

// [dv/tb_adcacc_ctrl.sv]
`default_nettype none
module tb_adcacc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Bench
  logic mclk_i = '0, sys_rst_i = '1, lpo_clk_en_i = '0, burst_mode_enable_i = '0;
  logic conv_start_i = '0, done_clear_i = '0, sfr_wr_i = '0, sfr_rd_i = '0, core_done_i;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
  logic [11:0] core_code_i;
  logic conversion_clock_o, core_start_o, core_track_o, eight_bit_select_o;
  logic twelve_bit_select_o, input_gain_select_o, conversion_done_flag_o, busy_o;
  int n_mismatch = 0, n_tests = 0, cyc = 0, n_done = 0;
  adcacc_ctrl i_adcacc_ctrl (.*);
  adcacc_core_model i_adcacc_core_model (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .start_i(core_start_o), .tick_i(conversion_clock_o), .done_o(core_done_i),
    .code_o(core_code_i));
  always #4 mclk_i = ~mclk_i;
  // Oscillator tick every sixth cycle; ceiling cuts a hang short
  always @(posedge mclk_i) begin
    cyc++;
    lpo_clk_en_i <= (cyc % 6 == 0);
    if (core_done_i === 1'b1) n_done++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) {sfr_wr_i, sfr_addr_i, sfr_wdata_i} <= {1'b1, a, d};
    @(posedge mclk_i) sfr_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i) {sfr_rd_i, sfr_addr_i} <= {1'b1, a};
    @(posedge mclk_i) sfr_rd_i <= 1'b0;
    #1 cmp8(sfr_rdata_o, exp);
  endtask
  task automatic rd16(input logic [15:0] exp);
    rd(8'hBE, exp[15:8]);
    rd(8'hBD, exp[7:0]);
  endtask
  task automatic conv(input int trk_exp, input int sp_exp);
    int trk = 0, sp = 0, last = -1, bad = 0;
    @(posedge mclk_i) conv_start_i <= 1'b1;
    @(posedge mclk_i) conv_start_i <= 1'b0;
    for (int i = 0; i < 2000; i++) begin
      #1;
      if (conversion_done_flag_o === 1'b1) break;
      bad += (busy_o === 1'b1 && core_track_o === core_start_o);
      if (busy_o === 1'b1 && conversion_clock_o === 1'b1) begin
        trk += (core_start_o === 1'b0);
        sp = (last < 0) ? 0 : i - last;
        last = i;
      end
      @(posedge mclk_i);
    end
    cmp8(8'(conversion_done_flag_o), 8'h01);
    cmp8(8'(trk), 8'(trk_exp));
    cmp8(8'(sp), 8'(sp_exp));
    cmp8(8'(bad), 8'h00);
    @(posedge mclk_i) done_clear_i <= 1'b1;
    @(posedge mclk_i) done_clear_i <= 1'b0;
  endtask
  task automatic t_regs();
    rd(8'hBC, 8'hF8);
    rd(8'hBA, 8'h00);
    rd(8'h00, 8'h00);
    #1 cmp8({7'h00, core_track_o}, 8'h01);
    wr(8'hBC, 8'h05);
    #1 cmp8({6'h00, eight_bit_select_o, input_gain_select_o}, 8'h03);
    wr(8'hBA, 8'hC0);
    #1 cmp8({7'h00, twelve_bit_select_o}, 8'h01);
    rd(8'hBA, 8'h80);
  endtask
  task automatic t_accum();
    wr(8'hBC, 8'h12);
    wr(8'hBA, 8'h40);
    wr(8'hBD, 8'h00);
    wr(8'hBE, 8'h00);
    conv(3, 3);
    conv(3, 3);
    rd16(16'h0246);
    wr(8'hBA, 8'h10);
    rd16(16'h0091);
    wr(8'hBA, 8'h08);
    rd16(16'h0123);
    wr(8'hBA, 8'h18);
    rd16(16'h0048);
    wr(8'hBA, 8'h20);
    rd16(16'h2460);
    wr(8'hBA, 8'h00);
    rd16(16'h0246);
    conv(3, 3);
    rd16(16'h0123);
  endtask
  task automatic t_burst();
    @(posedge mclk_i) burst_mode_enable_i <= 1'b1;
    wr(8'hBC, 8'h08);
    wr(8'hBA, 8'h01);
    wr(8'hBD, 8'h00);
    wr(8'hBE, 8'h00);
    n_done = 0;
    conv(0, 12);
    cmp8(8'(n_done), 8'h04);
    rd16(16'h048C);
    wr(8'hBC, 8'h00);
    wr(8'hBA, 8'h03);
    wr(8'hBD, 8'h00);
    wr(8'hBE, 8'h00);
    n_done = 0;
    conv(0, 6);
    cmp8(8'(n_done), 8'h10);
    rd16(16'h1230);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_accum();
    t_burst();
    stop_test();
  end
endmodule // tb_adcacc_ctrl
`default_nettype wire

// [include/adcacc_pkg.sv]
`default_nettype none
package adcacc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_ACC_CFG   = 8'hBA;
  localparam logic [7:0] ADDR_CONV_CFG  = 8'hBC;
  localparam logic [7:0] ADDR_RES_LOW   = 8'hBD;
  localparam logic [7:0] ADDR_RES_HIGH  = 8'hBE;
  localparam logic [7:0] RST_ACC_CFG    = 8'h00;
  localparam logic [7:0] RST_CONV_CFG   = 8'hF8;
  // ==========================================================
  // Field positions
  localparam int DIV_MSB   = 7;
  localparam int DIV_LSB   = 3;
  localparam int EIGHT_BIT = 2;
  localparam int TRACK_BIT = 1;
  localparam int GAIN_BIT  = 0;
  localparam int TWELVE_BIT = 7;
  localparam int ACCUM_BIT = 6;
  localparam int SJ_MSB    = 5;
  localparam int SJ_LSB    = 3;
  localparam int RPT_MSB   = 2;
  localparam int RPT_LSB   = 0;
  localparam logic [2:0] SJ_LEFT = 3'h4;
  // ==========================================================
  // Timing
  localparam logic [1:0] TRACK_DELAY_CLKS = 2'h3;
  localparam int LPO_FREQ_MHZ = 20;

  typedef enum logic [1:0] {
    ADCACC_IDLE  = 2'b00,
    ADCACC_TRACK = 2'b01,
    ADCACC_CONV  = 2'b10
  } adcacc_state_t;

  typedef struct packed {
    logic        start;
    logic [11:0] code;
  } adcacc_core_t;
endpackage
`default_nettype wire
